// file: ipor_pkg.sv
// Purpose: Constants for the identification and pin override register bank
// Assumes: Register access by index over the device's serial register port
// Notes:   Operation list below
//
// Operation
// R1 - Four-bit upper customer tag nibble, no operational effect, one-time programmable.
// R2 - Four-bit silicon revision field is read-only; host writes ignored.
// R3 - 32-bit user info field in low identification bits, one-time programmable.
// R4 - Reset request and gate both 1 hold whole chip in reset.
// R5 - Reset request never self clears; host clears request or gate.
// R6 - Gate bit 0, its default, makes reset request ignored.
// R7 - Reference override 1: control bit switches reference copy driver.
// R8 - Reference override 0: pin switches driver; control bit reads pin level.
// R9 - Driver four override 1: control bit switches driver four.
// R10 - Driver four override 0: pin switches driver; bit reads pin, read-only.
// R11 - Drivers two to four run only while second synthesis loop enabled.
// R12 - Driver three override 1: control bit switches driver three.
// R13 - Driver three override 0: pin controls driver; bit reads pin, ignores writes.
// R14 - Driver two override 1: control bit switches driver two.
// R15 - Driver two override 0: pin controls driver; bit reads pin, read-only.
// R16 - 16-bit protection mask makes masked registers permanently read-only to writes.
// R17 - Enable pins synchronised before readback or driver control.
// R18 - Override register bits 23 to 20 read 0 and ignore writes.
package ipor_pkg;
    localparam logic [3:0] ADDR_TAG     = 4'h1;
    localparam logic [3:0] ADDR_PINS    = 4'h2;
    localparam int         TAG_W        = 48;
    localparam int         PINS_W       = 24;
    localparam int         BIT_HOLD     = 19;
    localparam int         BIT_GATE     = 18;
    localparam int         BIT_REF      = 17;
    localparam int         BIT_REF_OVR  = 16;
    localparam int         BIT_D4       = 15;
    localparam int         BIT_D4_OVR   = 14;
    localparam int         BIT_D3       = 13;
    localparam int         BIT_D3_OVR   = 12;
    localparam int         BIT_D2       = 11;
    localparam int         BIT_D2_OVR   = 10;
    localparam int         NUM_PINS     = 4;
    localparam logic [23:0] PINS_WMASK  = 24'h0FFC00;
    localparam logic [23:0] PINS_RESET  = 24'h000000;
    localparam logic [7:0]  PRODUCT_ID  = 8'h5A;  // Arbitrary value
    localparam logic [3:0]  REVISION    = 4'h1;   // Arbitrary value
endpackage : ipor_pkg

// file: ipor_sync_if.sv
// Purpose: Carries raw and synchronised enable pins
// Assumes: Single clock
// Notes:   Bit order ref, two, three, four
`timescale 1ns/1ns
interface ipor_sync_if;
    logic [3:0] raw;
    logic [3:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface : ipor_sync_if

// file: ipor_pin_sync.sv
// Purpose: Two-flop synchroniser for the external enable pins
// Assumes: Synchronous active-low reset
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ns
module ipor_pin_sync (
    input wire logic    clk,
    input wire logic    rstn,
    ipor_sync_if.snk    pins
);
    logic [3:0] meta_r;
    logic [3:0] meta_nxt;
    logic [3:0] sync_r;
    logic [3:0] sync_nxt;

    always_comb begin
        meta_nxt = pins.raw;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_r <= 4'h0;
            sync_r <= 4'h0;
        end else begin
            meta_r <= meta_nxt;  // [R17]
            sync_r <= sync_nxt;  // [R17]
        end
    end

    assign pins.synced = sync_r;
endmodule : ipor_pin_sync

// file: ipor_regs.sv
// Purpose: Identification register and pin readback/override register
// Assumes: Register port writes whole registers with a one-cycle strobe
// Notes:   Reads are combinational from flops; one-time programming load is a strobe
`timescale 1ns/1ns
module ipor_regs #(
    parameter int NUM_DRV = ipor_pkg::NUM_PINS,
    parameter int PROT_W  = 16
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [47:0] reg_wdata,
    output logic      [47:0] reg_rdata,
    input  wire logic        otp_load,
    input  wire logic [3:0]  otp_tag_hi,
    input  wire logic [31:0] otp_user_info,
    input  wire logic [PROT_W-1:0] otp_protect,
    input  wire logic        reference_copy_enable_pin,
    input  wire logic        driver_two_enable_pin,
    input  wire logic        driver_three_enable_pin,
    input  wire logic        driver_four_enable_pin,
    input  wire logic        second_synth_loop,
    output logic             reference_copy_driver,
    output logic             clock_driver_two,
    output logic             clock_driver_three,
    output logic             clock_driver_four,
    output logic             chip_hold_reset
);
    logic [3:0]  tag_hi_r;
    logic [3:0]  tag_hi_nxt;
    logic [31:0] user_info_r;
    logic [31:0] user_info_nxt;
    logic [PROT_W-1:0] protect_r;
    logic [PROT_W-1:0] protect_nxt;
    logic [23:0] pins_r;
    logic [23:0] pins_nxt;
    logic [3:0]  drv_r;
    logic [3:0]  drv_nxt;
    logic        hold_r;
    logic        hold_nxt;
    logic [3:0]  pin_lvl;
    logic [23:0] pins_view;
    logic        wr_tag;
    logic        wr_pins;
    logic [3:0]  drv_sel;
    logic [3:0]  drv_gate;

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks: the map has four driver pairs, the mask must reach index 2
    if (NUM_DRV != 4) begin : g_bad_num_drv
        $error("ipor_regs: NUM_DRV must be 4");
    end
    if (PROT_W <= ipor_pkg::ADDR_PINS) begin : g_bad_prot_w
        $error("ipor_regs: PROT_W too small for the pin register");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit positions of driver idx, in pin order ref, two, three, four
    function automatic int ctl_pos(input int idx);
        case (idx)
            0:       ctl_pos = ipor_pkg::BIT_REF;
            1:       ctl_pos = ipor_pkg::BIT_D2;
            2:       ctl_pos = ipor_pkg::BIT_D3;
            default: ctl_pos = ipor_pkg::BIT_D4;
        endcase
    endfunction : ctl_pos

    function automatic int ovr_pos(input int idx);
        case (idx)
            0:       ovr_pos = ipor_pkg::BIT_REF_OVR;
            1:       ovr_pos = ipor_pkg::BIT_D2_OVR;
            2:       ovr_pos = ipor_pkg::BIT_D3_OVR;
            default: ovr_pos = ipor_pkg::BIT_D4_OVR;
        endcase
    endfunction : ovr_pos

    ipor_sync_if sif ();
    assign sif.raw = {driver_four_enable_pin, driver_three_enable_pin,
                      driver_two_enable_pin, reference_copy_enable_pin};

    ipor_pin_sync u_sync (
        .clk  (clk),
        .rstn (rstn),
        .pins (sif.snk)
    );
    assign pin_lvl = sif.synced;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode; protected registers silently drop writes
    always_comb begin
        wr_tag  = reg_wr && reg_addr == ipor_pkg::ADDR_TAG
                  && !protect_r[ipor_pkg::ADDR_TAG];   // [R16]
        wr_pins = reg_wr && reg_addr == ipor_pkg::ADDR_PINS
                  && !protect_r[ipor_pkg::ADDR_PINS];  // [R16]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Identification fields; programming overrides a same-cycle serial write
    always_comb begin
        tag_hi_nxt    = tag_hi_r;
        user_info_nxt = user_info_r;
        if (wr_tag) begin
            tag_hi_nxt    = reg_wdata[39:36];  // [R1]
            user_info_nxt = reg_wdata[31:0];   // [R3]
        end
        if (otp_load) begin
            tag_hi_nxt    = otp_tag_hi;     // [R1]
            user_info_nxt = otp_user_info;  // [R3]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tag_hi_r    <= 4'h0;
            user_info_r <= 32'h0000_0000;
        end else begin
            tag_hi_r    <= tag_hi_nxt;
            user_info_r <= user_info_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Protection mask; bits only ever set, so the host cannot undo a lock
    always_comb begin
        protect_nxt = protect_r;
        if (otp_load) begin
            protect_nxt = protect_r | otp_protect;  // [R16]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            protect_r <= {PROT_W{1'b0}};
        end else begin
            protect_r <= protect_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin register; unused top nibble never stored
    always_comb begin
        pins_nxt = pins_r;
        if (wr_pins) begin
            pins_nxt = reg_wdata[23:0] & ipor_pkg::PINS_WMASK;  // [R18] [R5]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pins_r <= ipor_pkg::PINS_RESET;
        end else begin
            pins_r <= pins_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per driver source: override bit picks the stored bit, else the synchronised pin
    for (genvar i = 0; i < NUM_DRV; i++) begin : g_drv
        localparam int CTL = ctl_pos(i);
        localparam int OVR = ovr_pos(i);
        assign drv_sel[i] = pins_r[OVR] ? pins_r[CTL]   // [R7] [R9] [R12] [R14]
                                        : pin_lvl[i];   // [R8] [R10] [R13] [R15]
        // Reference copy driver does not depend on the second loop
        assign drv_gate[i] = (i == 0) ? 1'b1 : second_synth_loop;  // [R11]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Driver enables registered, so a pin change reaches them as one clean edge
    always_comb begin
        drv_nxt = drv_sel & drv_gate;  // [R11]
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            drv_r <= 4'h0;
        end else begin
            drv_r <= drv_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Chip hold follows the stored bits only; nothing here clears the request
    always_comb begin
        hold_nxt = pins_r[ipor_pkg::BIT_HOLD] && pins_r[ipor_pkg::BIT_GATE];  // [R4] [R6]
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;  // [R5]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readback; non-overridden control bits show the synchronised pin
    always_comb begin
        pins_view = pins_r;
        for (int i = 0; i < NUM_DRV; i++) begin
            pins_view[ctl_pos(i)] = drv_sel[i];  // [R8] [R10] [R13] [R15]
        end
        case (reg_addr)
            ipor_pkg::ADDR_TAG:  reg_rdata = {ipor_pkg::PRODUCT_ID, tag_hi_r,
                                              ipor_pkg::REVISION, user_info_r};  // [R2]
            ipor_pkg::ADDR_PINS: reg_rdata = {24'h000000, pins_view};            // [R18]
            default:             reg_rdata = 48'h0000_0000_0000;
        endcase
    end

    assign reference_copy_driver = drv_r[0];
    assign clock_driver_two      = drv_r[1];
    assign clock_driver_three    = drv_r[2];
    assign clock_driver_four     = drv_r[3];
    assign chip_hold_reset       = hold_r;
endmodule : ipor_regs

// file: ipor_regs_chk_asserts.sv
// Purpose: Port checks for ipor_regs
// Assumes: Index 2 is never write protected
// Notes:   Driver outputs follow a write by two edges
`timescale 1ns/1ns
module ipor_regs_chk (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [47:0] reg_wdata,
    input wire logic [47:0] reg_rdata,
    input wire logic        second_synth_loop,
    input wire logic        reference_copy_driver,
    input wire logic        clock_driver_two,
    input wire logic        clock_driver_three,
    input wire logic        clock_driver_four,
    input wire logic        chip_hold_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic w2;
    assign w2 = reg_wr && reg_addr == 4'h2;
    property p_hold; w2 && reg_wdata[19:18] == 2'h3 |-> ##2 chip_hold_reset; endproperty
    a_hold: assert property (p_hold) else $error("hold not taken");
    property p_gate; w2 && !reg_wdata[18] |-> ##2 !chip_hold_reset; endproperty
    a_gate: assert property (p_gate) else $error("hold without gate");
    // Only a write two edges back may release the hold
    property p_keep; !w2 ##1 chip_hold_reset |=> chip_hold_reset; endproperty
    a_keep: assert property (p_keep) else $error("hold cleared itself");
    property p_ref; w2 && reg_wdata[16] ##1 !w2 |=>
        reference_copy_driver == $past(reg_wdata[17], 2); endproperty
    a_ref: assert property (p_ref) else $error("ref driver wrong");
    property p_d4; w2 && reg_wdata[14] && second_synth_loop ##1 !w2 && second_synth_loop
        |=> clock_driver_four == $past(reg_wdata[15], 2); endproperty
    a_d4: assert property (p_d4) else $error("driver four wrong");
    property p_loop; !second_synth_loop [*3] |->
        !(clock_driver_two || clock_driver_three || clock_driver_four); endproperty
    a_loop: assert property (p_loop) else $error("driver on, loop off");
    property p_rev; reg_addr == 4'h1 |-> reg_rdata[35:32] == ipor_pkg::REVISION; endproperty
    a_rev: assert property (p_rev) else $error("revision wrong");
    property p_unused; reg_addr == 4'h2 |-> reg_rdata[23:20] == 4'h0; endproperty
    a_unused: assert property (p_unused) else $error("unused bits set");
    c_hold: cover property (chip_hold_reset);
    c_d4: cover property (clock_driver_four && second_synth_loop);
    c_ref: cover property (reference_copy_driver);
endmodule : ipor_regs_chk
bind ipor_regs ipor_regs_chk u_chk (.*);

// file: ipor_pin_board.sv
// Purpose: Board side source of enable pins and loop status
// Assumes: Levels move just after the clock edge
// Notes:   Order {loop, four, three, two, ref}
`timescale 1ns/1ns
module ipor_pin_board (
    input  wire logic       clk,
    input  wire logic [4:0] want,
    output logic      [4:0] level
);
    initial level = 5'h10;
    // Loop comes up with the board, so drivers may run
    always @(posedge clk) level <= want;
endmodule : ipor_pin_board

// file: id_and_pin_override_regs_test.sv
// Purpose: Self-checking bench for ipor_regs
// Assumes: 50 ns clock, inputs move 1 ns after the edge
// Notes:   Only index 1 is protected, to keep the checker valid
`timescale 1ns/1ns
module id_and_pin_override_regs_test;
    logic        clk, rstn, reg_wr, otp_load;
    logic [3:0]  reg_addr;
    logic [47:0] reg_wdata, reg_rdata;
    logic [4:0]  want, level, drv;
    int          n_mismatch = 0;
    int          checked = 0;
    ipor_regs dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .otp_load(otp_load),
        .otp_tag_hi(4'hA), .otp_user_info(32'h12345678), .otp_protect(16'h0002),
        .reference_copy_enable_pin(level[0]), .driver_two_enable_pin(level[1]),
        .driver_three_enable_pin(level[2]), .driver_four_enable_pin(level[3]),
        .second_synth_loop(level[4]), .reference_copy_driver(drv[0]),
        .clock_driver_two(drv[1]), .clock_driver_three(drv[2]),
        .clock_driver_four(drv[3]), .chip_hold_reset(drv[4]));
    ipor_pin_board u_board (.clk(clk), .want(want), .level(level));
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic wr(input logic [3:0] a, input logic [47:0] d);
        settle(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        settle(1);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [47:0] e);
        settle(1);
        reg_addr = a;
        #10 chk(reg_rdata, e, "rdata");
    endtask : rd
    task automatic outs(input int n, input logic [4:0] e);
        settle(n);
        chk({43'h0, drv}, {43'h0, e}, "drivers");
    endtask : outs
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Whole run is under 200 cycles; allow ten times that
    initial begin
        #(2000 * 50);
        n_mismatch++;
        close_out();
    end
    initial begin
        {rstn, reg_wr, otp_load, reg_addr, reg_wdata} = '0;
        want = 5'h10;
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        rd(4'h1, {ipor_pkg::PRODUCT_ID, 4'h0, ipor_pkg::REVISION, 32'h0});
        rd(4'h7, 48'h0);
        wr(4'h1, 48'hFFFFFFFFFFFF);
        rd(4'h1, {ipor_pkg::PRODUCT_ID, 4'hF, ipor_pkg::REVISION, 32'hFFFFFFFF});
        settle(1);
        otp_load = 1'b1;
        settle(1);
        otp_load = 1'b0;
        wr(4'h1, 48'h0);
        rd(4'h1, {ipor_pkg::PRODUCT_ID, 4'hA, ipor_pkg::REVISION, 32'h12345678});
        $display("end tag");
        want = 5'h1F;
        wr(4'h2, 48'h000000);
        outs(5, 5'h0F);
        rd(4'h2, 48'h02A800);
        wr(4'h2, 48'h015400);
        outs(2, 5'h00);
        rd(4'h2, 48'h015400);
        wr(4'h2, 48'h03FC00);
        outs(2, 5'h0F);
        want = 5'h0F;
        outs(3, 5'h01);
        $display("end pins");
        wr(4'h2, 48'hF80000);
        rd(4'h2, 48'h0AA800);
        outs(2, 5'h01);
        wr(4'h2, 48'h0C0000);
        outs(2, 5'h11);
        outs(6, 5'h11);
        wr(4'h2, 48'h080000);
        outs(2, 5'h01);
        $display("end hold");
        close_out();
    end
endmodule : id_and_pin_override_regs_test
